// file: design/pwmcg_top.sv
// Purpose: Clock generator and channel pipeline of an eight-channel PWM controller
// Assumes: Pins synchronous to clock; AHB-Lite single word transfers
// Notes:   Fault path to the pins is combinational so it acts without a clock
`timescale 1ns/1ps
module pwmcg_top #(
  parameter int NUM_CH = 8
) (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic      [31:0]                       hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  input  wire logic [2:0]                        fault_pin_in,
  input  wire logic                              fault_osc_fail,
  input  wire logic                              fault_adc_cmp,
  input  wire logic                              fault_timer_cmp,
  output logic      [pwmcg_pkg::NUM_CH-1:0]      high_side_out,
  output logic      [pwmcg_pkg::NUM_CH-1:0]      low_side_out,
  output logic                                   irq
);
  import pwmcg_pkg::*;

  typedef struct packed {
    logic                             rd_pend;
    logic                             wr_pend;
    logic [11:0]                      addr;
    logic [31:0]                      rdata;
    logic [PRE_W-1:0]                 pre_cnt;
    logic [DIV_W-1:0]                 cnt_a;
    logic [DIV_W-1:0]                 cnt_b;
    logic [31:0]                      clk_cfg;
    logic [NUM_CH-1:0]                enable;
    logic [NUM_CH-1:0]                sync_member_bit;
    logic [7:0]                       gray_cfg;
    logic [15:0]                      ov_sel;
    logic [15:0]                      ov_val;
    logic [13:0]                      fault_mode_config;
    logic [13:0]                      irq_stat;
    logic [13:0]                      irq_mask;
    logic [NUM_FAULT-1:0]             fault_prev;
    logic [NUM_CH-1:0][18:0]          mode;
    logic [NUM_CH-1:0][CNT_W-1:0]     prd;
    logic [NUM_CH-1:0][CNT_W-1:0]     dty;
    logic [NUM_CH-1:0][27:0]          dt;
    logic [NUM_CH-1:0][CNT_W-1:0]     cnt;
    logic [NUM_CH-1:0]                down;
    logic [NUM_CH-1:0][DT_W-1:0]      dt_cnt;
    logic [NUM_CH-1:0]                wave_prev;
    logic [3:0][1:0]                  gray;
    logic [NUM_CH-1:0]                out_h;
    logic [NUM_CH-1:0]                out_l;
  } pwmcg_state_type;

  pwmcg_state_type s_q;
  pwmcg_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Thirteen-way clock pick; codes above twelve give no clock
  function automatic logic sel_tick(input logic [3:0] sel, input logic [NUM_PRE-1:0] pre,
                                    input logic ta, input logic tb);
    if (sel < 4'(NUM_PRE))
      sel_tick = pre[sel];
    else if (sel == SEL_DIV_A)
      sel_tick = ta;
    else if (sel == SEL_DIV_B)
      sel_tick = tb;
    else
      sel_tick = 1'b0;
  endfunction

  // Linear divider: tick at the last count of factor; zero factor stops it
  function automatic logic div_hit(input logic src, input logic [DIV_W-1:0] fac,
                                   input logic [DIV_W-1:0] cnt);
    div_hit = src && (fac != 8'h00) && (cnt >= fac - 8'h01);
  endfunction

  function automatic logic [DIV_W-1:0] div_next(input logic src, input logic [DIV_W-1:0] fac,
                                                input logic [DIV_W-1:0] cnt);
    if (!src || fac == 8'h00)
      div_next = cnt;
    else if (cnt >= fac - 8'h01)
      div_next = 8'h00;
    else
      div_next = cnt + 8'h01;
  endfunction

  // Two-bit gray step, up 00-01-11-10, down the reverse
  function automatic logic [1:0] gray_step(input logic [1:0] g, input logic dn);
    case (g)
      2'b00:   gray_step = dn ? 2'b10 : 2'b01;
      2'b01:   gray_step = dn ? 2'b00 : 2'b11;
      2'b11:   gray_step = dn ? 2'b01 : 2'b10;
      default: gray_step = dn ? 2'b11 : 2'b00;
    endcase
  endfunction

  function automatic logic is_ch_reg(input logic [11:0] a, input logic [11:0] base);
    is_ch_reg = (a[11:5] == base[11:5]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational view of the pipeline

  logic [NUM_PRE-1:0]   pre_tick;
  logic                 tick_a;
  logic                 tick_b;
  logic                 src_a;
  logic                 src_b;
  logic [NUM_CH-1:0]    ch_tick;
  logic [NUM_CH-1:0]    wave;
  logic [NUM_CH-1:0]    dt_h;
  logic [NUM_CH-1:0]    dt_l;
  logic [NUM_FAULT-1:0] fault_raw;
  logic [NUM_FAULT-1:0] fault_act;
  logic                 fault_any;
  logic                 addr_ok;
  logic [31:0]          rd_val;

  always_comb
  begin
    // Prescaler enables; bit k fires once every 2^k cycles
    for (int k = 0; k < NUM_PRE; k++)
    begin
      pre_tick[k] = rst_b && ((s_q.pre_cnt & PRE_W'((1 << k) - 1)) == PRE_W'((1 << k) - 1)); // [R03] [R07] [R19]
    end
    // Codes above ten give no tick instead of an unknown select
    src_a  = sel_tick(s_q.clk_cfg[CLK_DIVIDER_A_SOURCE_SEL_LSB +: 4], pre_tick, 1'b0, 1'b0); // [R05]
    src_b  = sel_tick(s_q.clk_cfg[CLK_DIVIDER_B_SOURCE_SEL_LSB +: 4], pre_tick, 1'b0, 1'b0); // [R05]
    // A zero factor parks the divider and its tick
    tick_a = div_hit(src_a,
                     s_q.clk_cfg[CLK_DIVIDER_A_FACTOR_LSB +: DIV_W], s_q.cnt_a); // [R04] [R05] [R06]
    tick_b = div_hit(src_b,
                     s_q.clk_cfg[CLK_DIVIDER_B_FACTOR_LSB +: DIV_W], s_q.cnt_b); // [R04] [R05] [R06]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel pipeline

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      logic [CNT_W-1:0] src;
      logic             cpol;
      logic             zero;
      ch_tick[i] = sel_tick(s_q.mode[i][3:0], pre_tick, tick_a, tick_b); // [R02] [R18]
      src        = s_q.sync_member_bit[i] ? s_q.cnt[0] : s_q.cnt[i]; // [R11]
      cpol       = s_q.mode[i][MODE_CPOL_BIT];
      if (!s_q.enable[i])
        wave[i] = cpol;
      else if (s_q.gray_cfg[i/2])
        wave[i] = s_q.gray[i/2][(i % 2 == 0) ? 1 : 0]; // [R12]
      else
        wave[i] = (src >= s_q.dty[i]) ^ cpol;
      // Dead time: the rising side waits until the dead-time count drains
      zero = (s_q.dt_cnt[i] == 12'h000);
      if (s_q.mode[i][MODE_DTE_BIT])
      begin
        dt_h[i] = s_q.wave_prev[i] & zero; // [R13]
        dt_l[i] = ~s_q.wave_prev[i] & zero; // [R13]
      end
      else
      begin
        dt_h[i] = s_q.wave_prev[i];
        dt_l[i] = ~s_q.wave_prev[i];
      end
      dt_h[i] = dt_h[i] ^ s_q.mode[i][MODE_DTHI_BIT];
      dt_l[i] = dt_l[i] ^ s_q.mode[i][MODE_DTLI_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault detection

  always_comb
  begin
    // A set polarity bit makes that pin active high
    fault_raw = {fault_timer_cmp, fault_adc_cmp, fault_osc_fail,
                 fault_pin_in ^ ~s_q.fault_mode_config[2:0]}; // [R16]
    fault_act = fault_raw & s_q.fault_mode_config[FCFG_EN_LSB +: NUM_FAULT];
    fault_any = |fault_act;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb
  begin
    logic [2:0] ch;
    ch      = s_q.addr[4:2];
    rd_val  = RST_ZERO;
    addr_ok = 1'b1;
    case (s_q.addr)
      OFS_CLK:       rd_val = s_q.clk_cfg;
      OFS_ENABLE:    rd_val = {24'h000000, s_q.enable};
      OFS_SYNC:      rd_val = {24'h000000, s_q.sync_member_bit};
      OFS_GRAY:      rd_val = {24'h000000, s_q.gray_cfg};
      OFS_OV_SEL:    rd_val = {16'h0000, s_q.ov_sel};
      OFS_OV_VAL:    rd_val = {16'h0000, s_q.ov_val};
      OFS_FAULT_CFG: rd_val = {18'h00000, s_q.fault_mode_config};
      OFS_FAULT_STA: rd_val = {26'h0000000, fault_raw};
      OFS_IRQ_STAT:  rd_val = {18'h00000, s_q.irq_stat};
      OFS_IRQ_MASK:  rd_val = {18'h00000, s_q.irq_mask};
      default:       addr_ok = 1'b0;
    endcase
    if (!addr_ok)
    begin
      if (is_ch_reg(s_q.addr, OFS_CH_MODE))
        rd_val = {13'h0000, s_q.mode[ch]};
      else if (is_ch_reg(s_q.addr, OFS_CH_PRD))
        rd_val = {16'h0000, s_q.prd[ch]};
      else if (is_ch_reg(s_q.addr, OFS_CH_DTY))
        rd_val = {16'h0000, s_q.dty[ch]};
      else if (is_ch_reg(s_q.addr, OFS_CH_DT))
        rd_val = {4'h0, s_q.dt[ch]};
      else if (is_ch_reg(s_q.addr, OFS_CH_CNT))
        rd_val = {16'h0000, s_q.cnt[ch]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic [2:0]        wch;
    logic [13:0]       w1c;
    logic [NUM_CH-1:0] pend;
    s_d  = s_q;
    wch  = s_q.addr[4:2];
    w1c  = 14'h0000;
    pend = '0;

    // Bus slave: reads take one wait state so a preceding write is visible
    s_d.wr_pend = 1'b0;
    s_d.rd_pend = 1'b0;
    if (s_q.rd_pend)
      s_d.rdata = rd_val;
    if (hsel && hready && htrans[1])
    begin
      s_d.addr    = {haddr[11:2], 2'b00};
      s_d.wr_pend = hwrite;
      s_d.rd_pend = !hwrite;
    end
    if (s_q.wr_pend)
    begin
      case (s_q.addr)
        OFS_CLK:       s_d.clk_cfg = hwdata & 32'h0fff_0fff;
        OFS_ENABLE:    s_d.enable = hwdata[NUM_CH-1:0];
        OFS_SYNC:      s_d.sync_member_bit = hwdata[NUM_CH-1:0];
        OFS_GRAY:      s_d.gray_cfg = hwdata[7:0];
        OFS_OV_SEL:    s_d.ov_sel = hwdata[15:0];
        OFS_OV_VAL:    s_d.ov_val = hwdata[15:0];
        OFS_FAULT_CFG: s_d.fault_mode_config = hwdata[13:0] & 14'h3f07;
        OFS_IRQ_STAT:  w1c = hwdata[13:0];
        OFS_IRQ_MASK:  s_d.irq_mask = hwdata[13:0];
        default:
        begin
          if (is_ch_reg(s_q.addr, OFS_CH_MODE))
            s_d.mode[wch] = hwdata[18:0] & 19'h7_030f;
          else if (is_ch_reg(s_q.addr, OFS_CH_PRD))
            s_d.prd[wch] = hwdata[15:0];
          else if (is_ch_reg(s_q.addr, OFS_CH_DTY))
            s_d.dty[wch] = hwdata[15:0];
          else if (is_ch_reg(s_q.addr, OFS_CH_DT))
            s_d.dt[wch] = hwdata[27:0] & 28'hfff_0fff;
        end
      endcase
    end

    // Clock generator
    s_d.pre_cnt = s_q.pre_cnt + 10'h001; // [R03]
    s_d.cnt_a   = div_next(src_a,
                           s_q.clk_cfg[CLK_DIVIDER_A_FACTOR_LSB +: DIV_W], s_q.cnt_a); // [R04] [R05]
    s_d.cnt_b   = div_next(src_b,
                           s_q.clk_cfg[CLK_DIVIDER_B_FACTOR_LSB +: DIV_W], s_q.cnt_b); // [R04] [R05]

    // Channel counters
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (!s_q.enable[i])
      begin
        s_d.cnt[i]  = 16'h0000;
        s_d.down[i] = 1'b0;
      end
      else if (ch_tick[i])
      begin
        if (!s_q.mode[i][MODE_CALG_BIT] || !s_q.down[i])
        begin
          if (s_q.cnt[i] >= s_q.prd[i])
          begin
            pend[i] = !s_q.mode[i][MODE_CALG_BIT];
            if (s_q.mode[i][MODE_CALG_BIT])
            begin
              s_d.down[i] = 1'b1; // [R10]
              s_d.cnt[i]  = (s_q.cnt[i] == 16'h0000) ? 16'h0000 : s_q.cnt[i] - 16'h0001;
            end
            else
              s_d.cnt[i] = 16'h0000; // [R10]
          end
          else
            s_d.cnt[i] = s_q.cnt[i] + 16'h0001; // [R10]
        end
        else if (s_q.cnt[i] <= 16'h0001)
        begin
          s_d.cnt[i]  = 16'h0000;
          s_d.down[i] = 1'b0;
          pend[i]     = 1'b1;
        end
        else
          s_d.cnt[i] = s_q.cnt[i] - 16'h0001; // [R10]
      end

      // Dead-time counter reloads on each wave edge, drains on channel clock
      s_d.wave_prev[i] = wave[i];
      if (wave[i] != s_q.wave_prev[i])
        s_d.dt_cnt[i] = wave[i] ? s_q.dt[i][DT_W-1:0] : s_q.dt[i][DT_LOW_LSB +: DT_W]; // [R13]
      else if (ch_tick[i] && s_q.dt_cnt[i] != 12'h000)
        s_d.dt_cnt[i] = s_q.dt_cnt[i] - 12'h001; // [R13]

      // Override replaces each side independently
      s_d.out_h[i] = s_q.ov_sel[i] ? s_q.ov_val[i] : dt_h[i]; // [R14]
      s_d.out_l[i] = s_q.ov_sel[OV_LOW_LSB + i] ? s_q.ov_val[OV_LOW_LSB + i] : dt_l[i]; // [R14]
    end

    // Gray counters step at each period end of the even channel of the pair
    for (int p = 0; p < NUM_CH / 2; p++)
    begin
      if (s_q.gray_cfg[p] && pend[2 * p])
        s_d.gray[p] = gray_step(s_q.gray[p], s_q.gray_cfg[GRAY_DOWN_LSB + p]); // [R12]
    end

    // Sticky events; a new event wins over a clear in the same cycle
    s_d.fault_prev = fault_act;
    s_d.irq_stat   = (s_q.irq_stat & ~w1c) | {fault_act & ~s_q.fault_prev, pend};

    // Reset overrides every update above
    if (!rst_b)
    begin
      s_d = '0; // [R06] [R07] [R18]
    end
  end

  // No clock means no update, so gating the clock freezes all registered state
  always_ff @(posedge clock)
  begin
    s_q <= s_d; // [R08]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata    = s_q.rdata;
  assign hreadyout = !s_q.rd_pend;
  assign hresp     = 1'b0;
  assign irq       = |(s_q.irq_stat & s_q.irq_mask); // [R17]

  // Fault path bypasses the flops so it acts even without clock edges
  assign high_side_out = s_q.out_h & ~{NUM_CH{fault_any}}; // [R01] [R15]
  assign low_side_out  = s_q.out_l & ~{NUM_CH{fault_any}}; // [R01] [R15]

endmodule // pwmcg_top

// file: design/pwmcg_pkg.sv
// Purpose: Constants for the eight-channel PWM clock generator and channel frame
// Assumes: One bus clock, AHB-Lite register access, 32-bit aligned words
// Notes:   Offsets are byte addresses
// How it works
// R01 - Eight channels, each driving a high-side and low-side output pair.
// R02 - Shared generator gives thirteen clocks; each channel picks one.
// R03 - Power-of-two prescaler gives bus clock divided by 1 up to 1024.
// R04 - Two linear dividers, A and B, divide by 1 to 255.
// R05 - Each divider's source select picks the prescaler output it divides.
// R06 - Divider factors and sources reset to zero; factor zero stops that clock.
// R07 - At reset every prescaler output except the undivided clock is idle; the code also holds the undivided clock idle while rst_b is low.
// R08 - Stopping and restarting the bus clock keeps all state intact.
// R09 - Software enables the peripheral clock before any access.
// R10 - Each channel has a 16-bit up/down counter on its selected clock.
// R11 - Sync member bit makes a comparator use the channel-zero counter.
// R12 - One 2-bit gray counter per channel pair drives both outputs.
// R13 - Dead-time stage turns each wave into safe complementary signals.
// R14 - Override stage can replace either signal with a software level.
// R15 - Fault forces both pins asynchronously, above every other source.
// R16 - Six faults: three pins with chosen polarity, three internal active high.
// R17 - One interrupt request line to the system interrupt controller.
// R18 - Channel clock select picks one of thirteen clocks; resets to undivided.
// R19 - Generated clocks are one-cycle enables in the bus clock domain.
package pwmcg_pkg;
  localparam int NUM_CH    = 8;
  localparam int NUM_FAULT = 6;
  localparam int NUM_PRE   = 11;
  localparam int CNT_W     = 16;
  localparam int DT_W      = 12;
  localparam int DIV_W     = 8;
  localparam int PRE_W     = 10;
  localparam int IRQ_ID    = 36;

  localparam logic [3:0] SEL_DIV_A = 4'hb;
  localparam logic [3:0] SEL_DIV_B = 4'hc;

  // Register byte offsets
  localparam logic [11:0] OFS_CLK       = 12'h000;
  localparam logic [11:0] OFS_ENABLE    = 12'h004;
  localparam logic [11:0] OFS_SYNC      = 12'h008;
  localparam logic [11:0] OFS_GRAY      = 12'h00c;
  localparam logic [11:0] OFS_OV_SEL    = 12'h010;
  localparam logic [11:0] OFS_OV_VAL    = 12'h014;
  localparam logic [11:0] OFS_FAULT_CFG = 12'h018;
  localparam logic [11:0] OFS_FAULT_STA = 12'h01c;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h020;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h024;
  localparam logic [11:0] OFS_CH_MODE   = 12'h040;
  localparam logic [11:0] OFS_CH_PRD    = 12'h060;
  localparam logic [11:0] OFS_CH_DTY    = 12'h080;
  localparam logic [11:0] OFS_CH_DT     = 12'h0a0;
  localparam logic [11:0] OFS_CH_CNT    = 12'h0c0;

  // Field positions
  localparam int CLK_DIVIDER_A_FACTOR_LSB  = 0;
  localparam int CLK_DIVIDER_A_SOURCE_SEL_LSB  = 8;
  localparam int CLK_DIVIDER_B_FACTOR_LSB  = 16;
  localparam int CLK_DIVIDER_B_SOURCE_SEL_LSB  = 24;
  localparam int GRAY_DOWN_LSB = 4;
  localparam int OV_LOW_LSB    = 8;
  localparam int FCFG_EN_LSB   = 8;
  localparam int IRQ_FAULT_LSB = 8;
  localparam int MODE_CALG_BIT = 8;
  localparam int MODE_CPOL_BIT = 9;
  localparam int MODE_DTE_BIT  = 16;
  localparam int MODE_DTHI_BIT = 17;
  localparam int MODE_DTLI_BIT = 18;
  localparam int DT_LOW_LSB    = 16;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage

// file: tb/pwmcg_fault_src.sv
// Purpose: Fault sources on the far side of the PWM block
// Assumes: Requests change by non-blocking assignment after a rising edge
// Notes:   An idle fault pin rests at the inverse of its active level
`timescale 1ns/1ps
module pwmcg_fault_src
(
  input  wire logic [5:0] fault_req,
  input  wire logic [2:0] fault_pol,
  output logic      [2:0] fault_pin_in,
  output logic            fault_osc_fail,
  output logic            fault_adc_cmp,
  output logic            fault_timer_cmp
);
  assign fault_pin_in    = fault_req[2:0] ~^ fault_pol;
  assign fault_osc_fail  = fault_req[3];
  assign fault_adc_cmp   = fault_req[4];
  assign fault_timer_cmp = fault_req[5];
endmodule // pwmcg_fault_src

// file: tb/pwmcg_assertions.sv
// Purpose: Port-level checks of the PWM clock generator and channel frame
// Assumes: One bus master, hready tied to hreadyout
// Notes:   Fault config and irq mask are rebuilt from observed writes
`timescale 1ns/1ps
module pwmcg_assertions #(
  parameter int NUM_CH = 8
) (
  input wire logic                         clock,
  input wire logic                         rst_b,
  input wire logic                         hsel,
  input wire logic [31:0]                  haddr,
  input wire logic [1:0]                   htrans,
  input wire logic                         hwrite,
  input wire logic [31:0]                  hwdata,
  input wire logic                         hready,
  input wire logic [31:0]                  hrdata,
  input wire logic                         hreadyout,
  input wire logic                         hresp,
  input wire logic [2:0]                   fault_pin_in,
  input wire logic                         fault_osc_fail,
  input wire logic                         fault_adc_cmp,
  input wire logic                         fault_timer_cmp,
  input wire logic [pwmcg_pkg::NUM_CH-1:0] high_side_out,
  input wire logic [pwmcg_pkg::NUM_CH-1:0] low_side_out,
  input wire logic                         irq
);
  import pwmcg_pkg::*;
  logic        wr_q;
  logic [11:0] wa_q;
  logic [31:0] cfg_q;
  logic [31:0] msk_q;
  logic [5:0]  raw;
  logic        fault_any;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wr_q  <= 1'b0;
      wa_q  <= 12'h000;
      cfg_q <= 32'h0000_0000;
      msk_q <= 32'h0000_0000;
    end
    else if (hready)
    begin
      wr_q <= hsel && htrans[1] && hwrite;
      wa_q <= {haddr[11:2], 2'b00};
      if (wr_q && wa_q == OFS_FAULT_CFG)
        cfg_q <= hwdata;
      if (wr_q && wa_q == OFS_IRQ_MASK)
        msk_q <= hwdata;
    end
  end
  // Pin faults match their chosen level; internal ones are active high
  assign raw       = {fault_timer_cmp, fault_adc_cmp, fault_osc_fail,
                      fault_pin_in ~^ cfg_q[2:0]};
  assign fault_any = |(raw & cfg_q[13:8]);
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_hresp_okay: assert property (hresp == 1'b0)
    else $error("slave response not OKAY");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite
    |=> hreadyout) else $error("write stalled");
  a_ready_short: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_idle_ready: assert property (hreadyout && !(hsel && htrans[1]) |=> hreadyout)
    else $error("wait state without transfer");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data changed outside a read");
  a_reset_state: assert property ($rose(rst_b) |-> high_side_out == '0
    && low_side_out == '0 && !irq && hrdata == 32'h0000_0000)
    else $error("outputs not idle after reset");
  a_fault_low: assert property (fault_any |-> high_side_out == '0
    && low_side_out == '0) else $error("pins not forced by fault");
  a_irq_masked: assert property (msk_q == 32'h0000_0000 && $past(msk_q) == 32'h0000_0000
    |-> !irq) else $error("irq with all sources masked");
endmodule // pwmcg_assertions

// file: tb/test_pwm_clock_gen_and_channel_frame.sv
// Purpose: Self-checking bench for the PWM clock generator and channel frame
// Assumes: Bus clock only; fault sources held by the partner model
// Notes:   Clock rates are compared as ratios of channel 0 periods
`timescale 1ns/1ps
module test_pwm_clock_gen_and_channel_frame;
  import pwmcg_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  fault_pin_in;
  logic        fault_osc_fail;
  logic        fault_adc_cmp;
  logic        fault_timer_cmp;
  logic [7:0]  high_side_out;
  logic [7:0]  low_side_out;
  logic        irq;
  logic [5:0]  fault_req = 6'h00;
  logic [2:0]  fault_pol = 3'b101;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          tests_run = 0;
  always #2 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  pwmcg_top #(.NUM_CH(8)) u_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_pin_in(fault_pin_in),
    .fault_osc_fail(fault_osc_fail), .fault_adc_cmp(fault_adc_cmp),
    .fault_timer_cmp(fault_timer_cmp), .high_side_out(high_side_out),
    .low_side_out(low_side_out), .irq(irq));
  pwmcg_fault_src u_src (.fault_req(fault_req), .fault_pol(fault_pol),
    .fault_pin_in(fault_pin_in), .fault_osc_fail(fault_osc_fail),
    .fault_adc_cmp(fault_adc_cmp), .fault_timer_cmp(fault_timer_cmp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready, sampled settled at the falling edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge clock);
    while (hready_ok() == 1'b0)
    begin
      n++;
      if (n > 64)
      begin
        error_cnt++;
        report_and_stop;
      end
      @(negedge clock);
    end
    rd = hrdata;
    @(posedge clock);
  endtask
  function automatic logic hready_ok();
    return hreadyout === 1'b1;
  endfunction
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
  endtask
  // Cycles between the second and third rising edge of channel 0 high side
  task automatic run_ch(input logic [3:0] sel, output int t);
    logic p;
    int   e;
    int   n;
    xfer(1'b1, OFS_ENABLE, 32'h0);
    xfer(1'b1, OFS_CH_MODE, {28'h0, sel});
    xfer(1'b1, OFS_ENABLE, 32'h1);
    p = high_side_out[0];
    e = 0;
    t = 0;
    for (n = 0; n < 12000 && e < 3; n++)
    begin
      @(negedge clock);
      if (high_side_out[0] === 1'b1 && p === 1'b0)
        e++;
      if (e == 2)
        t++;
      p = high_side_out[0];
    end
    if (e == 1 || e == 2)
    begin
      error_cnt++;
      report_and_stop;
    end
    @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_regs;
    xfer(1'b0, OFS_CLK, 32'h0);
    chk(rd, RST_ZERO);
    xfer(1'b0, OFS_CH_MODE + 12'h01c, 32'h0);
    chk(rd, RST_ZERO);
    xfer(1'b1, 12'h03c, 32'hffff_ffff);
    xfer(1'b0, 12'h03c, 32'h0);
    chk(rd, RST_ZERO);
    xfer(1'b1, OFS_CLK, 32'hffff_ffff);
    xfer(1'b0, OFS_CLK, 32'h0);
    chk(rd, 32'h0fff_0fff);
  endtask
  task automatic test_rates;
    int t0;
    int t;
    int k;
    xfer(1'b1, OFS_CH_PRD, 32'h2);
    xfer(1'b1, OFS_CH_DTY, 32'h1);
    run_ch(4'h0, t0);
    chk(32'(t0 > 1), 32'h1);
    for (k = 1; k <= 10; k += 3)
    begin
      run_ch(k[3:0], t);
      chk(32'(t), 32'(t0 << k));
    end
    xfer(1'b1, OFS_CLK, 32'h0105_0203);
    run_ch(SEL_DIV_A, t);
    chk(32'(t), 32'(t0 * 12));
    run_ch(SEL_DIV_B, t);
    chk(32'(t), 32'(t0 * 10));
    xfer(1'b1, OFS_CLK, 32'h0);
    run_ch(SEL_DIV_A, t);
    chk(32'(t), 32'h0);
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h1);
  endtask
  task automatic test_sync;
    xfer(1'b1, OFS_CH_MODE, 32'h0);
    xfer(1'b1, OFS_CH_DTY + 12'h004, 32'h1);
    xfer(1'b1, OFS_SYNC, 32'h2);
    xfer(1'b1, OFS_ENABLE, 32'h3);
    repeat (4) @(negedge clock);
    repeat (3)
    begin
      chk({31'h0, high_side_out[1]}, {31'h0, high_side_out[0]});
      @(negedge clock);
    end
    @(posedge clock);
    xfer(1'b1, OFS_ENABLE, 32'h0);
  endtask
  task automatic test_faults;
    int id;
    xfer(1'b1, OFS_OV_SEL, 32'hffff);
    xfer(1'b1, OFS_OV_VAL, 32'h5aa5);
    repeat (3) @(negedge clock);
    chk({16'h0, high_side_out, low_side_out}, 32'ha55a);
    @(posedge clock);
    xfer(1'b1, OFS_OV_VAL, 32'hffff);
    for (id = 0; id < 6; id++)
    begin
      xfer(1'b1, OFS_FAULT_CFG, (32'h100 << id) | 32'h5);
      fault_req <= 6'h01 << id;
      @(negedge clock);
      chk({16'h0, high_side_out, low_side_out}, 32'h0);
      @(posedge clock);
      xfer(1'b0, OFS_FAULT_STA, 32'h0);
      chk(rd, 32'h1 << id);
      fault_req <= 6'h00;
      @(negedge clock);
      chk({16'h0, high_side_out, low_side_out}, 32'hffff);
      @(posedge clock);
    end
    xfer(1'b1, OFS_FAULT_CFG, 32'h5);
    fault_req <= 6'h3f;
    @(negedge clock);
    chk({16'h0, high_side_out, low_side_out}, 32'hffff);
    @(posedge clock);
    fault_req <= 6'h00;
  endtask
  task automatic test_irq;
    xfer(1'b1, OFS_IRQ_STAT, 32'hffff_ffff);
    xfer(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd, RST_ZERO);
    xfer(1'b1, OFS_IRQ_MASK, 32'h800);
    xfer(1'b1, OFS_FAULT_CFG, 32'h800);
    fault_req <= 6'h08;
    repeat (3) @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    @(posedge clock);
    fault_req <= 6'h00;
    xfer(1'b1, OFS_IRQ_STAT, 32'h800);
    repeat (2) @(negedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Register traffic starts only once the bus clock runs and reset is gone
  initial
  begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    test_regs;
    test_rates;
    test_sync;
    test_faults;
    test_irq;
    report_and_stop;
  end
endmodule // test_pwm_clock_gen_and_channel_frame
bind pwmcg_top pwmcg_assertions #(.NUM_CH(NUM_CH)) u_chk (.clock(clock), .rst_b(rst_b),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .fault_pin_in(fault_pin_in), .fault_osc_fail(fault_osc_fail),
  .fault_adc_cmp(fault_adc_cmp), .fault_timer_cmp(fault_timer_cmp),
  .high_side_out(high_side_out), .low_side_out(low_side_out), .irq(irq));
